/* logic/cw2_decode.sv */
// Second configuration word decoder with Avalon-MM access
// Behaviour
// - Every unimplemented position of the word, bit 11 among them, reads back as one.
// - Debugger-select zero gives the two serial programming pins to the debugger, one leaves them as I/O.
// - Brown-out select one picks the low trip point, zero the high one.
// - Stack reset enable one resets on stack overflow or underflow, zero does not.
// - Multiplier enable one turns the 4x multiplier on, zero keeps it off.
// - Protect field 11 allows self-writes anywhere.
// - Protect field 10 blocks 000h-1FFh and allows 200h-7FFh.
// - Protect field 01 blocks 000h-3FFh and allows 400h-7FFh.
// - Protect field 00 blocks every self-write.
//
// The implementer's own choices: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module cw2_decode (
    input  wire logic                 sys_clk_in,           // 200 MHz clock
    input  wire logic                 rst_in,               // Sync reset, active high
    input  wire logic [13:0]          nvm_word_in,          // Stored word from nonvolatile array
    input  wire logic                 nvm_valid_in,         // Word present, same domain
    input  wire logic [3:0]           avs_address_in,       // Byte address
    input  wire logic                 avs_read_in,          // Read strobe
    input  wire logic                 avs_write_in,         // Write strobe
    input  wire logic [31:0]          avs_writedata_in,     // Write data
    input  wire logic [3:0]           avs_byteenable_in,    // Byte enables
    output logic [31:0]               avs_readdata_out,     // Read data
    output logic                      avs_waitrequest_out,  // Wait request
    input  wire logic [10:0]          self_write_addr_in,   // Self-write target address
    input  wire logic                 stack_fault_in,       // Overflow or underflow pulse
    input  wire logic                 hv_entry_in,          // High voltage seen on master clear
    input  wire logic                 prog_entry_req_in,    // Programming entry key seen
    output cw2_pkg::cw2_ctrl_t        ctrl_out,             // Decoded settings
    output logic                      self_write_ok_out,    // Self-write permitted
    output logic                      stack_reset_out,      // Reset request on stack fault
    output logic                      prog_entry_out,       // Programming entry granted
    output logic                      pins_to_debugger_out  // Serial prog pins owned by debugger
);
    import cw2_pkg::*;

    cw2_state_t st_ff;
    cw2_state_t nxt_st;

    // Self-write permission for an address under a protect setting
    function automatic logic write_allowed(input logic [1:0] wrt, input logic [10:0] addr);
        case (wrt)
            WRT_OFF: write_allowed = 1'b1;
            WRT_512: write_allowed = (addr >= BOUND_HALF);
            WRT_1K:  write_allowed = (addr >= BOUND_QUARTER);
            WRT_ALL: write_allowed = 1'b0;
            default: write_allowed = 1'b0;
        endcase
    endfunction

    logic [13:0] word_view;
    logic        rd_hit;

    // Stored word with unimplemented positions forced high
    assign word_view = st_ff.word_ff | UNIMPL_MASK;

    // Decoded settings
    always_comb begin
        ctrl_out.low_volt_prog_enable     = word_view[POS_LVP];
        ctrl_out.debugger_owns_pins       = ~word_view[POS_DBG];
        ctrl_out.brownout_trip_select     = word_view[POS_BROWNOUT_TRIP_SELECT];
        ctrl_out.stack_fault_reset_enable = word_view[POS_STK];
        ctrl_out.freq_multiplier_enable   = word_view[POS_PLL];
        ctrl_out.flash_self_write_protect = word_view[POS_WRT +: 2];
    end

    // Consumers of the settings
    assign pins_to_debugger_out = ~word_view[POS_DBG];
    assign stack_reset_out      = word_view[POS_STK] & stack_fault_in;
    assign prog_entry_out       = prog_entry_req_in & (word_view[POS_LVP] | hv_entry_in);
    assign self_write_ok_out    = write_allowed(word_view[POS_WRT +: 2], self_write_addr_in);

    // Bus handshake: reads wait one cycle, writes complete at once
    assign rd_hit              = avs_read_in & st_ff.rdvalid_ff;
    assign avs_waitrequest_out = avs_read_in & ~st_ff.rdvalid_ff;
    assign avs_readdata_out    = st_ff.rdata_ff;

    // Next state
    always_comb begin
        nxt_st = st_ff;
        nxt_st.rdvalid_ff = avs_read_in & ~st_ff.rdvalid_ff;
        if (nvm_valid_in && !st_ff.loaded_ff) begin
            nxt_st.word_ff   = nvm_word_in;
            nxt_st.loaded_ff = 1'b1;
        end
        if (avs_write_in && avs_address_in == OFF_LOAD && avs_byteenable_in[0] && avs_writedata_in[0]) begin
            nxt_st.loaded_ff = 1'b0;  // Reload from the array
        end
        if (avs_write_in && avs_address_in == OFF_CHECK) begin
            if (avs_byteenable_in[0]) begin
                nxt_st.chk_addr_ff[7:0] = avs_writedata_in[7:0];
            end
            if (avs_byteenable_in[1]) begin
                nxt_st.chk_addr_ff[10:8] = avs_writedata_in[10:8];
            end
        end
        if (avs_read_in && !st_ff.rdvalid_ff) begin
            case (avs_address_in)
                OFF_RAW:    nxt_st.rdata_ff = {18'h00000, word_view};
                OFF_LOAD:   nxt_st.rdata_ff = {31'h00000000, st_ff.loaded_ff};
                OFF_STATUS: nxt_st.rdata_ff = {25'h0000000, ctrl_out};
                OFF_CHECK:  nxt_st.rdata_ff = {write_allowed(word_view[POS_WRT +: 2], st_ff.chk_addr_ff),
                                               20'h00000, st_ff.chk_addr_ff};
                default:    nxt_st.rdata_ff = 32'h00000000;
            endcase
        end
        if (rd_hit) begin
            nxt_st.rdvalid_ff = 1'b0;
        end
    end

    // State register
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            st_ff.word_ff     <= CW2_RESET;
            st_ff.loaded_ff   <= 1'b0;
            st_ff.rdvalid_ff  <= 1'b0;
            st_ff.rdata_ff    <= 32'h00000000;
            st_ff.chk_addr_ff <= 11'h000;
        end else begin
            st_ff <= nxt_st;
        end
    end
endmodule
`default_nettype wire

/* logic/cw2_pkg.sv */
// Package for the second configuration word decoder
package cw2_pkg;
    localparam int          CW2_WIDTH      = 14;
    localparam int          CW2_ADDR_W     = 4;
    localparam int          FLASH_ADDR_W   = 11;
    // Register offsets (byte addresses)
    localparam logic [3:0]  OFF_RAW        = 4'h0;
    localparam logic [3:0]  OFF_LOAD       = 4'h4;
    localparam logic [3:0]  OFF_STATUS     = 4'h8;
    localparam logic [3:0]  OFF_CHECK      = 4'hC;
    // Field positions
    localparam int          POS_LVP        = 13;
    localparam int          POS_DBG        = 12;
    localparam int          POS_BROWNOUT_TRIP_SELECT       = 10;
    localparam int          POS_STK        = 9;
    localparam int          POS_PLL        = 8;
    localparam int          POS_WRT        = 0;
    // Positions that always read as one
    localparam logic [13:0] UNIMPL_MASK    = 14'h08EC;  // Bits 11, 7:5 and 3:2; reserved bit 4 reads as stored
    localparam logic [13:0] CW2_RESET      = 14'h3FFF;
    // Protection boundaries
    localparam logic [10:0] BOUND_HALF     = 11'h200;
    localparam logic [10:0] BOUND_QUARTER  = 11'h400;
    localparam logic [1:0]  WRT_OFF        = 2'h3;
    localparam logic [1:0]  WRT_512        = 2'h2;
    localparam logic [1:0]  WRT_1K         = 2'h1;
    localparam logic [1:0]  WRT_ALL        = 2'h0;

    typedef struct packed {
        logic low_volt_prog_enable;
        logic debugger_owns_pins;
        logic brownout_trip_select;
        logic stack_fault_reset_enable;
        logic freq_multiplier_enable;
        logic [1:0] flash_self_write_protect;
    } cw2_ctrl_t;

    typedef struct packed {
        logic [13:0] word_ff;
        logic        loaded_ff;
        logic        rdvalid_ff;
        logic [31:0] rdata_ff;
        logic [10:0] chk_addr_ff;
    } cw2_state_t;
endpackage

/* sim/cw2_prog_model.sv */
// Programmer model that presents the stored configuration word
`timescale 1ns/1ps
`default_nettype none
module cw2_prog_model (
    input  wire logic [13:0] word_in,             // Word burnt by the tool
    input  wire logic        sys_clk_in,          // Clock
    output logic      [13:0] nvm_word_out = 14'h3FFF, // Stored word, erased
    output logic             nvm_valid_out = 1'b0 // Word present
);
    // Array follows the tool one edge later; every bit, the debug bit included, follows the tool
    always @(posedge sys_clk_in) begin
        nvm_word_out  <= word_in;
        nvm_valid_out <= 1'b1;
    end
endmodule
`default_nettype wire

/* sim/cw2_checker.sv */
// Port checker for the configuration word decoder
`timescale 1ns/1ps
`default_nettype none
module cw2_checker import cw2_pkg::*; (
    input wire logic               sys_clk_in,
    input wire logic               rst_in,
    input wire logic [3:0]         avs_address_in,
    input wire logic               avs_read_in,
    input wire logic [31:0]        avs_readdata_out,
    input wire logic               avs_waitrequest_out,
    input wire logic [10:0]        self_write_addr_in,
    input wire logic               stack_fault_in,
    input wire logic               stack_reset_out,
    input wire logic               self_write_ok_out,
    input wire logic               pins_to_debugger_out,
    input wire cw2_pkg::cw2_ctrl_t ctrl_out
);
    // Read completion and protect field
    wire logic       done = avs_read_in && !avs_waitrequest_out;
    wire logic [1:0] wp = ctrl_out.flash_self_write_protect;
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (rst_in);
    a_unimpl_ones: assert property (done && avs_address_in == OFF_RAW |-> &(avs_readdata_out[13:0] | ~UNIMPL_MASK))
        else $error("unimplemented bit read zero");
    a_pin_owner: assert property (pins_to_debugger_out == ctrl_out.debugger_owns_pins)
        else $error("pin owner wrong");
    a_status_view: assert property (done && avs_address_in == OFF_STATUS |-> avs_readdata_out[6:0] == ctrl_out)
        else $error("status view wrong");
    a_stack_reset: assert property (stack_reset_out == (ctrl_out.stack_fault_reset_enable && stack_fault_in))
        else $error("stack reset wrong");
    a_prot_off: assert property (wp == WRT_OFF |-> self_write_ok_out)
        else $error("write refused with protection off");
    a_prot_half: assert property (wp == WRT_512 |-> self_write_ok_out == (self_write_addr_in >= BOUND_HALF))
        else $error("lower block protection wrong");
    a_prot_quarter: assert property (wp == WRT_1K |-> self_write_ok_out == (self_write_addr_in >= BOUND_QUARTER))
        else $error("wider block protection wrong");
    a_prot_all: assert property (wp == WRT_ALL |-> !self_write_ok_out)
        else $error("write allowed with full protection");
endmodule
bind cw2_decode cw2_checker u_chk (.*);
`default_nettype wire

/* sim/cw2_decode_tb_top.sv */
// Self-checking bench for the configuration word decoder
`timescale 1ns/1ps
`default_nettype none
module cw2_decode_tb_top;
    import cw2_pkg::*;
    logic        sys_clk_in = 1'b0, rst_in = 1'b1, avs_read_in = 1'b0, avs_write_in = 1'b0, nvm_valid_in;
    logic        stack_fault_in = 1'b0, hv_entry_in = 1'b0, prog_entry_req_in = 1'b0, avs_waitrequest_out;
    logic        self_write_ok_out, stack_reset_out, prog_entry_out, pins_to_debugger_out;
    logic [3:0]  avs_address_in = 4'h0;
    logic [10:0] self_write_addr_in = 11'h000;
    logic [10:0] adr [6] = '{11'h000, 11'h1FF, 11'h200, 11'h3FF, 11'h400, 11'h7FF};
    logic [13:0] cfg_word = 14'h3FFF, nvm_word_in, w;
    logic [31:0] avs_writedata_in = 32'h0, avs_readdata_out, d;
    cw2_ctrl_t   ctrl_out;
    int          fails = 0, total_checks = 0;
    // Clock, programmer and design
    always #2.5 sys_clk_in = ~sys_clk_in;
    cw2_prog_model prog (.word_in(cfg_word), .sys_clk_in(sys_clk_in), .nvm_word_out(nvm_word_in), .nvm_valid_out(nvm_valid_in));
    cw2_decode dut (.*, .avs_byteenable_in(4'hF));
    // Permission expected from protect field and address
    function automatic logic ok(input logic [1:0] p, input logic [10:0] a);
        return p == 2'h3 || (p == 2'h2 && a >= 11'h200) || (p == 2'h1 && a >= 11'h400);
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    // One bus cycle, held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
        avs_address_in   <= a;
        avs_writedata_in <= wd;
        avs_read_in      <= !wr;
        avs_write_in     <= wr;
        @(posedge sys_clk_in);
        while (avs_waitrequest_out !== 1'b0) @(posedge sys_clk_in);
        d = avs_readdata_out;
        avs_read_in  <= 1'b0;
        avs_write_in <= 1'b0;
        @(posedge sys_clk_in);
    endtask
    task automatic wrap_up;
        if (fails == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // Main sequence over four stored words
    initial begin
        repeat (10) @(posedge sys_clk_in);
        rst_in <= 1'b0;
        @(posedge sys_clk_in);
        bus(0, OFF_RAW, 0);
        chk(d, 32'h3FFF); // Erased word
        bus(0, 4'h1, 0);
        chk(d, 0); // Unmapped
        for (int i = 0; i < 4; i++) begin
            w = (i[0] ? 14'h3FFC : 14'h0000) | 14'(i);
            cfg_word <= w;
            @(posedge sys_clk_in);
            bus(1, OFF_LOAD, 1);
            bus(1, OFF_RAW, 0);
            bus(0, OFF_RAW, 0);
            chk(d, 32'(w | UNIMPL_MASK)); // Readback
            bus(0, OFF_STATUS, 0);
            chk(d, {25'h0, w[13], ~w[12], w[10:8], w[1:0]}); // Settings
            bus(1, OFF_CHECK, 32'h3FF);
            bus(0, OFF_CHECK, 0);
            chk(d, {ok(w[1:0], 11'h3FF), 20'h0, 11'h3FF}); // Probe
            for (int j = 0; j < 8; j++) begin
                self_write_addr_in <= adr[j % 6];
                {prog_entry_req_in, hv_entry_in, stack_fault_in} <= 3'(j);
                @(negedge sys_clk_in);
                chk({self_write_ok_out, stack_reset_out, prog_entry_out, pins_to_debugger_out},
                    {ok(w[1:0], adr[j % 6]), w[9] & j[0], j[2] & (w[13] | j[1]), ~w[12]});
                @(posedge sys_clk_in);
            end
        end
        wrap_up();
    end
    // Watchdog
    initial begin
        repeat (5000) @(posedge sys_clk_in);
        fails++;
        wrap_up();
    end
endmodule
`default_nettype wire
